// [mdp_pins_model.sv]
// far side of the port pins: external devices, pull-ups and floating lines
`timescale 1ns/1ps
module mdp_pins_model (
  // block side
  input  wire logic       clk_i,
  input  wire logic [7:0] db_pin_o,
  input  wire logic [7:0] db_pin_oe_o,
  input  wire logic [7:0] db_pullup_o,
  input  wire logic [7:0] cp_pin_o,
  input  wire logic [7:0] cp_pin_oe_o,
  // external drivers
  input  wire logic [7:0] db_ext_val_i,
  input  wire logic [7:0] db_ext_drv_i,
  input  wire logic [7:0] cp_ext_val_i,
  input  wire logic [7:0] cp_ext_drv_i,
  output logic [7:0]      db_pin_i,
  output logic [7:0]      cp_pin_i
);
  logic [7:0] flt = 8'h5a;
  // undriven lines without a pull-up toggle every cycle, so the pin filter holds its last accepted level
  always @(posedge clk_i) flt <= ~flt;
  // wire level from every party's enable
  assign db_pin_i = (db_pin_oe_o & db_pin_o) | (~db_pin_oe_o & db_ext_drv_i & db_ext_val_i)
                  | (~db_pin_oe_o & ~db_ext_drv_i & (db_pullup_o | flt));
  assign cp_pin_i = (cp_pin_oe_o & cp_pin_o) | (~cp_pin_oe_o & cp_ext_drv_i & cp_ext_val_i)
                  | (~cp_pin_oe_o & ~cp_ext_drv_i & flt);
endmodule

// [mdp_pkg.sv]
// types for the mode dependent ports
package mdp_pkg;
  typedef enum logic [1:0] {
    MDP_MODE_RSVD,
    MDP_MODE_EXP_NOROM,
    MDP_MODE_EXP_ROM,
    MDP_MODE_SINGLE
  } mdp_mode_t;
  typedef enum logic [1:0] {
    MDP_RUN,
    MDP_SW_STBY,
    MDP_HW_STBY
  } mdp_power_t;
endpackage

// [mdp_ports.sv]
// data bus port and control pin port with avalon register slave
// Contract
// - data bus direction bit 1 drives pin, 0 makes input.
// - data bus value read gives latch for outputs, pin for inputs.
// - data bus pull-up on only when pull-up bit 1 and direction 0.
// - modes 1 and 2 data bus pins carry external data bus.
// - mode 3 data bus pins are general purpose i/o.
// - reset or hardware standby clears data bus registers, pins float.
// - software standby keeps registers; bus modes float, mode 3 holds state.
// - data bus pull-ups only in mode 3, off in reset and hardware standby.
// - control port direction bit 1 output, 0 input.
// - control direction resets 40 in bus modes with bit 6 locked, else 00.
// - control value bit 6 reads clock pin; others read/write reset zero.
// - control value read gives latch for outputs, pin for inputs.
// - control bits 0 to 2 are i/o feeding interrupts and trigger.
// - driven shared interrupt pins feed data value to interrupt logic.
// - bus modes put read, write, address strobes on bits 3 to 5.
// - bit 6 outputs clock in bus modes, in mode 3 by direction.
// - bus modes take external wait request on bit 7.
// - reset makes mode 3 pins inputs, bus modes take bus functions.
// - hardware standby floats every control pin.
// - software standby holds control pins, strobes and clock held high.
// - mode 1 expanded no rom, mode 2 expanded rom, mode 3 single chip.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "mdp_regs.svh"
module mdp_ports (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // operating state
  input  wire mdp_pkg::mdp_mode_t mode_i,
  input  wire logic              sw_standby_i,
  input  wire logic              hw_standby_i,
  // avalon slave
  input  wire logic [15:0]       avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [7:0]        avs_writedata_i,
  output logic [7:0]             avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // external bus side from the bus controller
  input  wire logic [7:0]        ext_data_out_i,
  input  wire logic              ext_data_drive_i,
  input  wire logic              bus_read_strobe_n_i,
  input  wire logic              bus_write_strobe_n_i,
  input  wire logic              bus_addr_strobe_n_i,
  input  wire logic              sys_clock_i,
  output logic [7:0]             ext_data_in_o,
  output logic                   bus_wait_n_o,
  // peripheral feeds
  output logic                   ext_interrupt_0_o,
  output logic                   ext_interrupt_1_o,
  output logic                   ext_interrupt_2_o,
  output logic                   conversion_trigger_n_o,
  // data bus port pins
  input  wire logic [7:0]        db_pin_i,
  output logic [7:0]             db_pin_o,
  output logic [7:0]             db_pin_oe_o,
  output logic [7:0]             db_pullup_o,
  // control pin port pins
  input  wire logic [7:0]        cp_pin_i,
  output logic [7:0]             cp_pin_o,
  output logic [7:0]             cp_pin_oe_o
);
  logic [7:0] databus_port_direction;
  logic [7:0] databus_port_value;
  logic [7:0] databus_port_pullup_enable;
  logic [7:0] control_pin_port_direction;
  logic [7:0] control_pin_port_value;
  logic [7:0] db_s1, db_s2, db_s3, db_lvl;
  logic [7:0] cp_s1, cp_s2, cp_s3, cp_lvl;
  logic       bus_mode, single_mode, ack;
  logic       wr_db_dir, wr_db_val, wr_db_pu, wr_cp_dir, wr_cp_val;
  logic [7:0] next_db_o, next_db_oe, next_db_pu;
  logic [7:0] next_cp_o, next_cp_oe, next_cp_mux;
  logic [7:0] next_rdata;
  logic       cp_clk_hold;
  logic [7:0] next_feed;

  // merge latch and pin by direction
  function automatic logic [7:0] mdp_port_read(input logic [7:0] dir, input logic [7:0] lat,
                                              input logic [7:0] pin);
    mdp_port_read = (dir & lat) | (~dir & pin);
  endfunction

  // mode decode
  assign bus_mode    = (mode_i == mdp_pkg::MDP_MODE_EXP_NOROM) ||
                       (mode_i == mdp_pkg::MDP_MODE_EXP_ROM);
  assign single_mode = !bus_mode;

  // register address match for a write in the ack cycle
  function automatic logic mdp_wr_hit(input logic wr, input logic ak, input logic [15:0] adr,
                                      input logic [15:0] ofs);
    mdp_wr_hit = wr && ak && (adr == ofs);
  endfunction

  // one wait cycle per access, ack pulse ends it
  assign wr_db_dir = mdp_wr_hit(avs_write_i, ack, avs_address_i, `MDP_OFS_DB_DIR);
  assign wr_db_val = mdp_wr_hit(avs_write_i, ack, avs_address_i, `MDP_OFS_DB_VALUE);
  assign wr_db_pu  = mdp_wr_hit(avs_write_i, ack, avs_address_i, `MDP_OFS_DB_PULLUP);
  assign wr_cp_dir = mdp_wr_hit(avs_write_i, ack, avs_address_i, `MDP_OFS_CP_DIR);
  assign wr_cp_val = mdp_wr_hit(avs_write_i, ack, avs_address_i, `MDP_OFS_CP_VALUE);

  // bus handshake
  // ack alternates so a request held through its answer is served once
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  // waitrequest is high except in the ack cycle
  // registered, so the answer never hangs on a same-cycle request path
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
    end
  end

  // data bus pin synchroniser, level accepted when last two agree
  // a one-cycle glitch on a pin never reaches the read path
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      db_s1  <= 8'h00;
      db_s2  <= 8'h00;
      db_s3  <= 8'h00;
      db_lvl <= 8'h00;
    end else begin
      db_s1  <= db_pin_i;
      db_s2  <= db_s1;
      db_s3  <= db_s2;
      db_lvl <= (db_s2 & db_s3) | (db_lvl & (db_s2 ^ db_s3));
    end
  end

  // control pin synchroniser, same filter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cp_s1  <= 8'h00;
      cp_s2  <= 8'h00;
      cp_s3  <= 8'h00;
      cp_lvl <= 8'h00;
    end else begin
      cp_s1  <= cp_pin_i;
      cp_s2  <= cp_s1;
      cp_s3  <= cp_s2;
      cp_lvl <= (cp_s2 & cp_s3) | (cp_lvl & (cp_s2 ^ cp_s3));
    end
  end

  // data bus port direction
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      databus_port_direction <= `MDP_RST_DB;
    end else if (wr_db_dir) begin
      databus_port_direction <= avs_writedata_i;
    end
  end

  // data bus port latch
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      databus_port_value <= `MDP_RST_DB;
    end else if (wr_db_val) begin
      databus_port_value <= avs_writedata_i;
    end
  end

  // data bus port pull-up control
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      databus_port_pullup_enable <= `MDP_RST_DB;
    end else if (wr_db_pu) begin
      databus_port_pullup_enable <= avs_writedata_i;
    end
  end

  // control pin port direction, bit 6 locked set in bus modes
  // the clock pin stays an output whatever software writes there
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      control_pin_port_direction <= bus_mode ? `MDP_RST_CP_DIR_EXP
                                             : `MDP_RST_CP_DIR_SC;
    end else if (wr_cp_dir) begin
      control_pin_port_direction <= bus_mode ? (avs_writedata_i | `MDP_MASK_CLK)
                                             : avs_writedata_i;
    end
  end

  // control pin port latch, bit 6 has no latch
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      control_pin_port_value <= `MDP_RST_CP_VALUE;
    end else if (wr_cp_val) begin
      control_pin_port_value <= avs_writedata_i & ~`MDP_MASK_CLK;
    end
  end

  // read data mux, unmapped reads as zero, direction registers write only
  // input bits come from the filtered level, never the raw pin
  always_comb begin
    next_rdata = 8'h00;
    unique case (avs_address_i)
      `MDP_OFS_DB_VALUE:  next_rdata = mdp_port_read(databus_port_direction,
                                                     databus_port_value, db_lvl);
      `MDP_OFS_DB_PULLUP: next_rdata = databus_port_pullup_enable;
      `MDP_OFS_CP_VALUE: begin
        next_rdata = mdp_port_read(control_pin_port_direction & ~`MDP_MASK_CLK,
                                   control_pin_port_value, cp_lvl);
      end
      default:            next_rdata = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 8'h00;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // data bus port pin drive
  // bus modes ignore all three port registers
  always_comb begin
    next_db_o  = 8'h00;
    next_db_oe = 8'h00;
    next_db_pu = 8'h00;
    if (reset_i || hw_standby_i) begin
      next_db_oe = 8'h00;
    end else if (bus_mode) begin
      next_db_o  = ext_data_out_i;
      next_db_oe = (ext_data_drive_i && !sw_standby_i) ? 8'hff : 8'h00;
    end else begin
      next_db_o  = databus_port_value;
      next_db_oe = databus_port_direction;
      next_db_pu = databus_port_pullup_enable & ~databus_port_direction;
    end
  end

  // data bus port pin drive flops
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      db_pin_o    <= 8'h00;
      db_pin_oe_o <= 8'h00;
    end else begin
      db_pin_o    <= next_db_o;
      db_pin_oe_o <= next_db_oe;
    end
  end

  // pull-up flops
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      db_pullup_o <= 8'h00;
    end else begin
      db_pullup_o <= next_db_pu;
    end
  end

  // filtered data bus level to the bus controller
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_data_in_o <= 8'h00;
    end else begin
      ext_data_in_o <= db_lvl;
    end
  end

  // control pin port pin function mux
  // strobes and clock park high in software standby
  always_comb begin
    next_cp_mux = control_pin_port_value;
    next_cp_oe  = control_pin_port_direction;
    cp_clk_hold = sw_standby_i;
    next_cp_mux[`MDP_BIT_CLK] = cp_clk_hold ? 1'b1 : sys_clock_i;
    if (bus_mode) begin
      next_cp_mux[`MDP_BIT_RD] = sw_standby_i ? 1'b1 : bus_read_strobe_n_i;
      next_cp_mux[`MDP_BIT_WR] = sw_standby_i ? 1'b1 : bus_write_strobe_n_i;
      next_cp_mux[`MDP_BIT_AS] = sw_standby_i ? 1'b1 : bus_addr_strobe_n_i;
      next_cp_oe[`MDP_BIT_RD]   = 1'b1;
      next_cp_oe[`MDP_BIT_WR]   = 1'b1;
      next_cp_oe[`MDP_BIT_AS]   = 1'b1;
      next_cp_oe[`MDP_BIT_CLK]  = 1'b1;
      next_cp_oe[`MDP_BIT_WAIT] = 1'b0;
    end
  end

  // control pin outputs, reset and hardware standby float
  always_comb begin
    next_cp_o = next_cp_mux;
    if (reset_i || hw_standby_i) begin
      next_cp_o = 8'h00;
    end
  end

  // control pin port output value flops
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      cp_pin_o <= 8'h00;
    end else begin
      cp_pin_o <= next_cp_o;
    end
  end

  // control pin port enable flops
  always_ff @(posedge clk_i) begin
    if (reset_i || hw_standby_i) begin
      cp_pin_oe_o <= 8'h00;
    end else begin
      cp_pin_oe_o <= next_cp_oe;
    end
  end

  // peripheral feeds: driven pins pass the latch, inputs the pin level
  // a driven shared pin can raise a request of its own
  always_comb begin
    next_feed = mdp_port_read(control_pin_port_direction, control_pin_port_value, cp_lvl);
  end

  // interrupt feeds, bit 0 to int 2 and bit 2 to int 0
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_interrupt_2_o <= 1'b1;
      ext_interrupt_1_o <= 1'b1;
      ext_interrupt_0_o <= 1'b1;
    end else begin
      ext_interrupt_2_o <= next_feed[0];
      ext_interrupt_1_o <= next_feed[1];
      ext_interrupt_0_o <= next_feed[2];
    end
  end

  // conversion trigger shares bit 0
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      conversion_trigger_n_o <= 1'b1;
    end else begin
      conversion_trigger_n_o <= next_feed[0];
    end
  end

  // external wait request, idle outside the bus modes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_wait_n_o <= 1'b1;
    end else begin
      bus_wait_n_o <= bus_mode ? cp_lvl[`MDP_BIT_WAIT] : 1'b1;
    end
  end
endmodule

// [mdp_ports_props.sv]
// concurrent checks on the mode dependent port block
`timescale 1ns/1ps
module mdp_ports_props (
  // clock, reset and state
  input wire logic               clk_i,
  input wire logic               reset_i,
  input wire mdp_pkg::mdp_mode_t mode_i,
  input wire logic               sw_standby_i,
  input wire logic               hw_standby_i,
  // register bus
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic               avs_waitrequest_o,
  // bus controller side
  input wire logic [7:0]         ext_data_out_i,
  input wire logic               ext_data_drive_i,
  input wire logic               bus_read_strobe_n_i,
  input wire logic               bus_write_strobe_n_i,
  input wire logic               bus_addr_strobe_n_i,
  input wire logic               sys_clock_i,
  input wire logic               bus_wait_n_o,
  input wire logic               ext_interrupt_2_o,
  input wire logic               conversion_trigger_n_o,
  // pins
  input wire logic [7:0]         db_pin_o,
  input wire logic [7:0]         db_pin_oe_o,
  input wire logic [7:0]         db_pullup_o,
  input wire logic [7:0]         cp_pin_o,
  input wire logic [7:0]         cp_pin_oe_o
);
  logic busm;
  logic run;
  // expanded modes and normal running
  assign busm = (mode_i == mdp_pkg::MDP_MODE_EXP_NOROM) || (mode_i == mdp_pkg::MDP_MODE_EXP_ROM);
  assign run  = busm && !sw_standby_i && !hw_standby_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ack_wait_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
    else $error("request not answered in time");
  ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("acknowledge longer than one cycle");
  pullup_input_a: assert property ((db_pullup_o & db_pin_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");
  bus_pullup_a: assert property (busm |-> db_pullup_o == 8'h00)
    else $error("pull-up on in expanded mode");
  hw_float_a: assert property (hw_standby_i |=> (db_pin_oe_o | db_pullup_o | cp_pin_oe_o) == 8'h00)
    else $error("pin driven in hardware standby");
  bus_data_a: assert property (run && ext_data_drive_i |=> db_pin_oe_o == 8'hff && db_pin_o == $past(ext_data_out_i))
    else $error("data bus not passed through");
  strobe_out_a: assert property (run |=> cp_pin_oe_o[6:3] == 4'hf && cp_pin_o[6:3] == $past({sys_clock_i, bus_addr_strobe_n_i, bus_write_strobe_n_i, bus_read_strobe_n_i}))
    else $error("strobes or clock not on pins");
  sw_high_a: assert property (busm && sw_standby_i && !hw_standby_i |=> cp_pin_o[6:3] == 4'hf && db_pin_oe_o == 8'h00)
    else $error("strobes not high in software standby");
  wait_idle_a: assert property (!busm |=> bus_wait_n_o)
    else $error("wait asserted in single chip mode");
  trig_same_a: assert property (ext_interrupt_2_o == conversion_trigger_n_o)
    else $error("trigger and interrupt feed differ");
  feed_latch_a: assert property (cp_pin_oe_o[0] && $stable(cp_pin_oe_o[0]) && $stable(cp_pin_o[0]) |-> ext_interrupt_2_o == cp_pin_o[0])
    else $error("interrupt feed not the driven value");
endmodule
bind mdp_ports mdp_ports_props chk_u (.clk_i, .reset_i, .mode_i, .sw_standby_i, .hw_standby_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .ext_data_out_i, .ext_data_drive_i,
  .bus_read_strobe_n_i, .bus_write_strobe_n_i, .bus_addr_strobe_n_i, .sys_clock_i,
  .bus_wait_n_o, .ext_interrupt_2_o, .conversion_trigger_n_o, .db_pin_o, .db_pin_oe_o,
  .db_pullup_o, .cp_pin_o, .cp_pin_oe_o);

// [mdp_regs.svh]
// register offsets, reset values and field positions for the mode dependent ports
`ifndef MDP_REGS_SVH
`define MDP_REGS_SVH
`define MDP_OFS_DB_PULLUP  16'hffae
`define MDP_OFS_DB_DIR     16'hffb4
`define MDP_OFS_CP_DIR     16'hffb5
`define MDP_OFS_DB_VALUE   16'hffb6
`define MDP_OFS_CP_VALUE   16'hffb7
`define MDP_RST_DB         8'h00
`define MDP_RST_CP_DIR_EXP 8'h40
`define MDP_RST_CP_DIR_SC  8'h00
`define MDP_RST_CP_VALUE   8'h00
`define MDP_BIT_CLK        6
`define MDP_BIT_RD         3
`define MDP_BIT_WR         4
`define MDP_BIT_AS         5
`define MDP_BIT_WAIT       7
`define MDP_MASK_CLK       8'h40
`define MDP_MASK_EXP_OWN   8'hf8
`endif

// [testbench.sv]
// self-checking bench for the mode dependent ports
`timescale 1ns/1ps
`include "mdp_regs.svh"
module testbench;
  logic               clk_i, reset_i, sw_standby_i, hw_standby_i, avs_read_i, avs_write_i;
  logic               ext_data_drive_i, bus_read_strobe_n_i, bus_write_strobe_n_i;
  logic               bus_addr_strobe_n_i, sys_clock_i, avs_waitrequest_o, bus_wait_n_o;
  logic               ext_interrupt_0_o, ext_interrupt_1_o, ext_interrupt_2_o;
  logic               conversion_trigger_n_o;
  mdp_pkg::mdp_mode_t mode_i;
  logic [15:0]        avs_address_i;
  logic [7:0]         avs_writedata_i, ext_data_out_i, db_pin_i, cp_pin_i, dx_val, cx_val, q;
  logic [7:0]         avs_readdata_o, db_pin_o, db_pin_oe_o, db_pullup_o, cp_pin_o, cp_pin_oe_o;
  logic [7:0]         ext_data_in_o;
  int                 failures, samples_checked, d, v, e, p, c, w, lv, x;
  mdp_ports dut_u (.clk_i, .reset_i, .mode_i, .sw_standby_i, .hw_standby_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .ext_data_out_i, .ext_data_drive_i, .bus_read_strobe_n_i, .bus_write_strobe_n_i,
    .bus_addr_strobe_n_i, .sys_clock_i, .ext_data_in_o, .bus_wait_n_o, .ext_interrupt_0_o,
    .ext_interrupt_1_o, .ext_interrupt_2_o, .conversion_trigger_n_o, .db_pin_i, .db_pin_o,
    .db_pin_oe_o, .db_pullup_o, .cp_pin_i, .cp_pin_o, .cp_pin_oe_o);
  mdp_pins_model far_u (.clk_i, .db_pin_o, .db_pin_oe_o, .db_pullup_o, .cp_pin_o, .cp_pin_oe_o,
    .db_ext_val_i(dx_val), .db_ext_drv_i(8'hff), .cp_ext_val_i(cx_val), .cp_ext_drv_i(8'hff),
    .db_pin_i, .cp_pin_i);
  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
    samples_checked++;
    if (got !== ex) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, ex, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] wd);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic start(input mdp_pkg::mdp_mode_t m);
    reset_i <= 1'b1;
    mode_i <= m;
    sw_standby_i <= 1'b0;
    hw_standby_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    conclude();
  end
  // main sequence
  initial begin
    {avs_read_i, avs_write_i, ext_data_drive_i, sys_clock_i} = 4'h0;
    {bus_read_strobe_n_i, bus_write_strobe_n_i, bus_addr_strobe_n_i} = 3'h7;
    {avs_address_i, avs_writedata_i, ext_data_out_i, dx_val, cx_val} = 48'h0;
    failures = 0;
    samples_checked = 0;
    x = $urandom(32'hd7d7);
    start(mdp_pkg::MDP_MODE_SINGLE);
    repeat (4) begin
      d = $urandom;
      v = $urandom;
      e = $urandom;
      p = $urandom;
      c = $urandom;
      w = $urandom;
      dx_val <= e[7:0];
      cx_val <= e[15:8];
      sys_clock_i <= c[8];
      bus(1'b1, `MDP_OFS_DB_DIR, d[7:0]);
      bus(1'b1, `MDP_OFS_DB_VALUE, v[7:0]);
      bus(1'b1, `MDP_OFS_DB_PULLUP, p[7:0]);
      bus(1'b1, `MDP_OFS_CP_DIR, c[7:0]);
      bus(1'b1, `MDP_OFS_CP_VALUE, w[7:0]);
      repeat (6) @(posedge clk_i);
      chk("db oe", d[7:0], db_pin_oe_o);
      chk("db out", d[7:0] & v[7:0], db_pin_o & db_pin_oe_o);
      chk("db pullup", p[7:0] & ~d[7:0], db_pullup_o);
      chk("cp oe", c[7:0], cp_pin_oe_o);
      lv = (((w & c) | ((e >> 8) & ~c)) & 32'hbf) | (c[6] ? {c[8], 6'h00} : (e >> 8) & 32'h40);
      chk("int feeds", lv[7:0] & 8'h07, {5'h00, ext_interrupt_0_o, ext_interrupt_1_o, ext_interrupt_2_o});
      chk("trigger", {7'h00, lv[0]}, {7'h00, conversion_trigger_n_o});
      bus(1'b0, `MDP_OFS_DB_VALUE, 8'h00);
      chk("db read", (v[7:0] & d[7:0]) | (e[7:0] & ~d[7:0]), q);
      bus(1'b0, `MDP_OFS_DB_PULLUP, 8'h00);
      chk("pullup reg", p[7:0], q);
      bus(1'b0, `MDP_OFS_CP_VALUE, 8'h00);
      chk("cp read", lv[7:0], q);
      sw_standby_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("sw hold", d[7:0], db_pin_oe_o);
      chk("sw cp hold", c[7:0], cp_pin_oe_o);
      sw_standby_i <= 1'b0;
    end
    bus(1'b0, `MDP_OFS_DB_DIR, 8'h00);
    chk("dir read", 8'h00, q);
    bus(1'b1, 16'hff00, 8'h5a);
    bus(1'b0, 16'hff00, 8'h00);
    chk("unmapped", 8'h00, q);
    hw_standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("hw db", 8'h00, db_pin_oe_o | db_pullup_o);
    chk("hw cp", 8'h00, cp_pin_oe_o);
    hw_standby_i <= 1'b0;
    bus(1'b0, `MDP_OFS_DB_PULLUP, 8'h00);
    chk("hw pullup reg", 8'h00, q);
    bus(1'b0, `MDP_OFS_DB_VALUE, 8'h00);
    chk("hw db read", e[7:0], q);
    for (x = 1; x < 3; x++) begin
      start(mdp_pkg::mdp_mode_t'(x[1:0]));
      v = $urandom;
      ext_data_out_i <= v[7:0];
      ext_data_drive_i <= 1'b1;
      {bus_addr_strobe_n_i, bus_write_strobe_n_i, bus_read_strobe_n_i} <= v[10:8];
      cx_val <= {v[11], 7'h00};
      bus(1'b1, `MDP_OFS_DB_PULLUP, 8'hff);
      bus(1'b1, `MDP_OFS_CP_DIR, 8'h00);
      repeat (6) @(posedge clk_i);
      chk("bus data", v[7:0], db_pin_o);
      chk("data in", v[7:0], ext_data_in_o);
      chk("bus pullup", 8'h00, db_pullup_o);
      chk("strobes", {5'h00, v[10:8]}, {5'h00, cp_pin_o[5:3]});
      chk("cp oe bus", 8'h78, cp_pin_oe_o);
      chk("wait in", {7'h00, v[11]}, {7'h00, bus_wait_n_o});
      sw_standby_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("sw db", 8'h00, db_pin_oe_o);
      chk("sw strobes", 8'h78, cp_pin_o & 8'h78);
      sw_standby_i <= 1'b0;
    end
    conclude();
  end
endmodule
